// [core/pdcs_top.v]
// Port device control and status registers behind an Avalon-MM slave
`timescale 1ns/1ns
`include "pdcs_defs.vh"
module pdcs_top #(
  parameter [2:0] MPS_SUPPORTED = `PDCS_MPS_SUPPORTED
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Error detection pulses from the port
  input  wire        err_corr_pulse,
  input  wire        err_nonfatal_pulse,
  input  wire        err_fatal_pulse,
  input  wire        err_unsup_pulse,
  // Auxiliary power presence pin
  input  wire        aux_pwr_present,
  // Control outputs
  output wire [2:0]  max_payload,
  output wire        aux_pm_en,
  output wire [3:0]  err_report_en,
  // Interrupt
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Limit a written payload code to the supported maximum
  function [2:0] clamp_mps;
    input [2:0] code;
    input [2:0] lim;
    begin
      if (code > lim) begin
        clamp_mps = lim;
      end else begin
        clamp_mps = code;
      end
    end
  endfunction

  // Address match against a register offset
  function addr_hit;
    input [8:0] addr;
    input [8:0] off;
    begin
      addr_hit = (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [2:0]  mps_ff;
  reg  [2:0]  nxt_mps;
  reg  [3:0]  err_en_ff;
  reg  [3:0]  nxt_err_en;
  reg         aux_pm_ff;
  reg         nxt_aux_pm;
  reg  [3:0]  mask_ff;
  reg  [3:0]  nxt_mask;
  reg         ack_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  reg         aux_s1_ff;
  reg         aux_s2_ff;
  reg         aux_s3_ff;
  reg         aux_det_ff;
  reg         nxt_aux_det;
  reg  [3:0]  sts_clr;
  reg  [3:0]  irq_clr;
  reg  [15:0] ctl_view;
  reg  [15:0] sts_view;

  wire        req;
  wire        take;
  wire        hit_ctl;
  wire        hit_irq_sts;
  wire        hit_irq_mask;
  wire [3:0]  err_evt;
  wire [3:0]  err_flags;
  wire [3:0]  irq_flags;
  wire        wr_ctl;
  wire        wr_mask;
  wire        rd_irq;
  wire        rd_cap;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request is taken

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign take            = req & ack_ff;

  always @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  assign hit_ctl      = addr_hit(avs_address, `PDCS_OFF_DEV_CTL_STS);
  assign hit_irq_sts  = addr_hit(avs_address, `PDCS_OFF_IRQ_STATUS);
  assign hit_irq_mask = addr_hit(avs_address, `PDCS_OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////////
  // Access strobes, valid at the edge that takes the request; the read capture strobe rd_cap is valid in the wait cycle

  assign wr_ctl  = take & avs_write & hit_ctl;
  assign wr_mask = take & avs_write & hit_irq_mask;
  assign rd_irq  = take & avs_read & hit_irq_sts;
  assign rd_cap  = avs_read & ~ack_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Error events

  // Latched whatever the reporting enables hold
  assign err_evt = {err_unsup_pulse,
                    err_fatal_pulse,
                    err_nonfatal_pulse,
                    err_corr_pulse};

  ////////////////////////////////////////////////////////////////////////////////
  // Control register writes

  always @* begin
    nxt_mps    = mps_ff;
    nxt_err_en = err_en_ff;
    nxt_aux_pm = aux_pm_ff;
    if (wr_ctl) begin
      if (avs_byteenable[0]) begin
        nxt_err_en = avs_writedata[`PDCS_CTL_ERR_EN_MSB:`PDCS_CTL_ERR_EN_LSB];
        nxt_mps    = clamp_mps(avs_writedata[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB],
                               MPS_SUPPORTED);
      end
      if (avs_byteenable[1]) begin
        nxt_aux_pm = avs_writedata[`PDCS_CTL_AUX_PM];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      mps_ff    <= `PDCS_RST_MPS;
      err_en_ff <= `PDCS_RST_ERR_EN;
      aux_pm_ff <= `PDCS_RST_AUX_PM;
    end else begin
      mps_ff    <= nxt_mps;
      err_en_ff <= nxt_err_en;
      aux_pm_ff <= nxt_aux_pm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt mask register

  always @* begin
    nxt_mask = mask_ff;
    if (wr_mask && avs_byteenable[0]) begin
      nxt_mask = avs_writedata[3:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      mask_ff <= `PDCS_RST_MASK;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clear strobes

  always @* begin
    sts_clr = 4'h0;
    irq_clr = 4'h0;
    if (wr_ctl && avs_byteenable[2]) begin
      sts_clr = avs_writedata[`PDCS_STS_ERR_MSB:`PDCS_STS_ERR_LSB];
    end
    if (rd_irq) begin
      // Only bits that were returned to software are cleared
      irq_clr = rdata_ff[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky flag banks

  pdcs_flags #(
    .WIDTH   (`PDCS_NUM_ERR)
  ) u_err_flags (
    .clk     (clk),
    .rst_n   (rst_n),
    .set_in  (err_evt),
    .clr_in  (sts_clr),
    .flags   (err_flags)
  );

  pdcs_flags #(
    .WIDTH   (`PDCS_NUM_ERR)
  ) u_irq_flags (
    .clk     (clk),
    .rst_n   (rst_n),
    .set_in  (err_evt),
    .clr_in  (irq_clr),
    .flags   (irq_flags)
  );

  assign irq = |(irq_flags & mask_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // Auxiliary power detection

  always @* begin
    nxt_aux_det = aux_det_ff;
    if (aux_s2_ff == aux_s3_ff) begin
      nxt_aux_det = aux_s3_ff;
    end
  end

  // Synchroniser idles at the status reset value, so no false drop after reset
  always @(posedge clk) begin
    if (!rst_n) begin
      aux_s1_ff <= `PDCS_RST_AUX_DET;
      aux_s2_ff <= `PDCS_RST_AUX_DET;
      aux_s3_ff <= `PDCS_RST_AUX_DET;
    end else begin
      aux_s1_ff <= aux_pwr_present;
      aux_s2_ff <= aux_s1_ff;
      aux_s3_ff <= aux_s2_ff;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      aux_det_ff <= `PDCS_RST_AUX_DET;
    end else begin
      aux_det_ff <= nxt_aux_det;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read views

  always @* begin
    ctl_view = 16'h0000;
    ctl_view[`PDCS_CTL_ERR_EN_MSB:`PDCS_CTL_ERR_EN_LSB] = err_en_ff;
    ctl_view[`PDCS_CTL_RLX_ORD]  = 1'b0;
    ctl_view[`PDCS_CTL_MPS_MSB:`PDCS_CTL_MPS_LSB] = mps_ff;
    ctl_view[`PDCS_CTL_EXT_TAG]  = 1'b0;
    ctl_view[`PDCS_CTL_PHANTOM]  = 1'b0;
    ctl_view[`PDCS_CTL_AUX_PM]   = aux_pm_ff;
    ctl_view[`PDCS_CTL_NO_SNOOP] = 1'b0;
    ctl_view[`PDCS_CTL_MRRS_MSB:`PDCS_CTL_MRRS_LSB] = `PDCS_RST_MRRS;
  end

  always @* begin
    sts_view = 16'h0000;
    sts_view[3:0] = err_flags;
    sts_view[`PDCS_STS_AUX_DET - `PDCS_STS_ERR_LSB]    = aux_det_ff;
    sts_view[`PDCS_STS_TRANS_PEND - `PDCS_STS_ERR_LSB] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle

  always @* begin
    nxt_rdata = rdata_ff;
    if (rd_cap) begin
      if (hit_ctl) begin
        nxt_rdata = {sts_view, ctl_view};
      end else if (hit_irq_sts) begin
        nxt_rdata = {28'h000_0000, irq_flags};
      end else if (hit_irq_mask) begin
        nxt_rdata = {28'h000_0000, mask_ff};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= `PDCS_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata  = rdata_ff;
  assign max_payload   = mps_ff;
  assign aux_pm_en     = aux_pm_ff;
  assign err_report_en = err_en_ff;

endmodule // pdcs_top

// [core/pdcs_defs.vh]
// Offsets, field positions, reset values and flag count of the port device control block
//
// What this block does
// - Relaxed-ordering permission always reads zero
// - Payload size writable, resets 000b, clamped
// - Extended-tag and phantom-function enables read zero
// - Aux power PM enable: read-write, resets zero
// - No-snoop permission always reads zero
// - Read request size fixed at 000b
// - Correctable-error flag sets on detection, resets zero
// - Non-fatal-error flag sets on detection, resets zero
// - Fatal-error flag sets on detection, resets zero
// - Unsupported-request flag sets on detection, resets zero
// - Flags latch regardless of enables, write-one clears
// - Aux-power-detected flag read-only, resets one
// - Transactions-pending flag fixed at zero
`ifndef PDCS_DEFS_VH
`define PDCS_DEFS_VH

// Register byte addresses
`define PDCS_ADDR_W           9
`define PDCS_OFF_DEV_CTL_STS  9'h0c8
`define PDCS_OFF_IRQ_STATUS   9'h100
`define PDCS_OFF_IRQ_MASK     9'h104

// Device control field positions
`define PDCS_CTL_ERR_EN_LSB   0
`define PDCS_CTL_ERR_EN_MSB   3
`define PDCS_CTL_RLX_ORD      4
`define PDCS_CTL_MPS_LSB      5
`define PDCS_CTL_MPS_MSB      7
`define PDCS_CTL_EXT_TAG      8
`define PDCS_CTL_PHANTOM      9
`define PDCS_CTL_AUX_PM       10
`define PDCS_CTL_NO_SNOOP     11
`define PDCS_CTL_MRRS_LSB     12
`define PDCS_CTL_MRRS_MSB     14

// Device status field positions
`define PDCS_STS_ERR_LSB      16
`define PDCS_STS_ERR_MSB      19
`define PDCS_STS_AUX_DET      20
`define PDCS_STS_TRANS_PEND   21

// Number of error flags
`define PDCS_NUM_ERR          4

// Reset values
`define PDCS_RST_MPS          3'h0
`define PDCS_RST_MRRS         3'h0
`define PDCS_RST_ERR_EN       4'h0
`define PDCS_RST_AUX_PM       1'b0
`define PDCS_RST_AUX_DET      1'b1
`define PDCS_RST_FLAGS        4'h0
`define PDCS_RST_MASK         4'h0
`define PDCS_RST_RDATA        32'h0000_0000

// Default supported payload size code
`define PDCS_MPS_SUPPORTED    3'h1

`endif

// [core/pdcs_flags.v]
// Sticky flag bank: set pulses win over clear pulses
`timescale 1ns/1ns
module pdcs_flags #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Set and clear strobes
  input  wire [WIDTH-1:0] set_in,
  input  wire [WIDTH-1:0] clr_in,
  // Flag state
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] flags_ff;
  wire [WIDTH-1:0] nxt_flags;

  // Set has priority so an event in a clear cycle survives
  assign nxt_flags = set_in | (flags_ff & ~clr_in);

  always @(posedge clk) begin
    if (!rst_n) begin
      flags_ff <= {WIDTH{1'b0}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule // pdcs_flags

// [tb/pdcs_asserts.sv]
// Concurrent checks on the port device control block
`timescale 1ns/1ns
module pdcs_asserts #(
  parameter [2:0] MPS_SUPPORTED = 3'h1
) (
  // Clock and reset
  input logic        clk,
  input logic        rst_n,
  // Register bus
  input logic [8:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0]  avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  // Events and pin
  input logic        err_corr_pulse,
  input logic        err_nonfatal_pulse,
  input logic        err_fatal_pulse,
  input logic        err_unsup_pulse,
  input logic        aux_pwr_present,
  // Outputs
  input logic [2:0]  max_payload,
  input logic        aux_pm_en,
  input logic [3:0]  err_report_en,
  input logic        irq
);
  ////////////////////
  wire [2:0] mps_exp = (avs_writedata[7:5] > MPS_SUPPORTED) ? MPS_SUPPORTED : avs_writedata[7:5];
  wire       evt     = err_corr_pulse | err_nonfatal_pulse | err_fatal_pulse | err_unsup_pulse;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_ctl;
    avs_write && !avs_waitrequest && avs_address == 9'h0c8;
  endsequence
  sequence s_rd_ctl;
    avs_read && !avs_waitrequest && avs_address == 9'h0c8;
  endsequence
  ////////////////////
  a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("No wait state on new request");
  a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Wait state longer than one cycle");
  a_mps_max: assert property (max_payload <= MPS_SUPPORTED)
    else $error("Payload code above limit");
  a_mps_store: assert property (
    s_wr_ctl ##0 avs_byteenable[0] |=> max_payload == $past(mps_exp))
    else $error("Payload code not clamped or stored");
  a_en_store: assert property (
    s_wr_ctl ##0 avs_byteenable[0] |=> err_report_en == $past(avs_writedata[3:0]))
    else $error("Report enables not stored");
  a_aux_store: assert property (
    s_wr_ctl ##0 avs_byteenable[1] |=> aux_pm_en == $past(avs_writedata[10]))
    else $error("Aux enable not stored");
  a_ctl_hold: assert property (
    !(avs_write && !avs_waitrequest) |=> $stable({max_payload, aux_pm_en}))
    else $error("Control changed without write");
  a_rsvd_zero: assert property (
    s_rd_ctl |-> (avs_readdata & 32'hffe0_fb10) == 32'h0000_0000)
    else $error("Fixed bit read nonzero");
  a_aux_det: assert property (s_rd_ctl ##0 aux_pwr_present |-> avs_readdata[20])
    else $error("Aux detected reads zero");
  a_irq_cause: assert property ($rose(irq) |-> $past(evt | avs_write))
    else $error("Interrupt without cause");
endmodule // pdcs_asserts

// [tb/pdcs_top_tb.sv]
// Self-checking bench for the port device control block
`timescale 1ns/1ns
`include "pdcs_defs.vh"
module pdcs_top_tb;
  localparam [8:0] A_CS = `PDCS_OFF_DEV_CTL_STS;
  localparam [8:0] A_IS = `PDCS_OFF_IRQ_STATUS;
  localparam [8:0] A_IM = `PDCS_OFF_IRQ_MASK;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  avs_address = 9'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [3:0]  err = 4'h0;
  logic        aux_pwr_present = 1'b1;
  logic [31:0] q;
  logic [3:0]  f;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [2:0]  max_payload;
  wire         aux_pm_en;
  wire  [3:0]  err_report_en;
  wire         irq;
  int          fail_count = 0;
  int          checks = 0;
  ////////////////////
  pdcs_top uut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .err_corr_pulse(err[0]), .err_nonfatal_pulse(err[1]), .err_fatal_pulse(err[2]),
    .err_unsup_pulse(err[3]), .aux_pwr_present(aux_pwr_present), .max_payload(max_payload),
    .aux_pm_en(aux_pm_en), .err_report_en(err_report_en), .irq(irq)
  );
  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(s, q, e);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    err <= m;
    @(posedge clk);
    err <= 4'h0;
  endtask
  ////////////////////
  task automatic t_reset;
    rd(A_CS, 32'h0010_0000, "reset word");
    chk("reset outputs", {max_payload, aux_pm_en, err_report_en}, 32'h0000_0000);
  endtask
  task automatic t_ctl;
    bus(1'b1, A_CS, 32'hffff_ffff, 4'h3);
    rd(A_CS, 32'h0010_042f, "control ones");
    chk("outputs ones", {max_payload, aux_pm_en, err_report_en}, 32'h0000_003f);
    bus(1'b1, A_CS, 32'h0000_0020, 4'h3);
    @(posedge clk);
    chk("outputs limit", {max_payload, aux_pm_en, err_report_en}, 32'h0000_0020);
    bus(1'b1, 9'h1fc, 32'hffff_ffff, 4'hf);
    rd(A_CS, 32'h0010_0020, "after unmapped");
    rd(9'h1fc, 32'h0000_0000, "unmapped read");
  endtask
  task automatic t_aux;
    aux_pwr_present <= 1'b0;
    repeat (8) @(posedge clk);
    rd(A_CS, 32'h0000_0020, "aux lost");
    aux_pwr_present <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b1, A_CS, 32'hffe0_0000, 4'hc);
    rd(A_CS, 32'h0010_0020, "aux back read only");
  endtask
  task automatic t_flags;
    f = 4'h0;
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      f[i] = 1'b1;
      rd(A_CS, {12'h001, f, 16'h0020}, "flag set");
    end
    bus(1'b1, A_CS, 32'h0005_0000, 4'h3);
    rd(A_CS, 32'h001f_0000, "no lane clear");
    bus(1'b1, A_CS, 32'h0005_0000, 4'h4);
    rd(A_CS, 32'h001a_0000, "clear 16 18");
    bus(1'b1, A_CS, 32'h000a_0000, 4'h4);
    rd(A_CS, 32'h0010_0000, "clear 17 19");
  endtask
  task automatic t_race;
    fork
      bus(1'b1, A_CS, 32'h0004_0000, 4'h4);
      pulse_late();
    join
    rd(A_CS, 32'h0014_0000, "set beats clear");
    bus(1'b1, A_CS, 32'h0004_0000, 4'h4);
  endtask
  task automatic pulse_late;
    @(posedge clk);
    pulse(4'h4);
  endtask
  task automatic t_irq;
    rd(A_IS, 32'h0000_000f, "irq status");
    rd(A_IS, 32'h0000_0000, "irq read clear");
    pulse(4'h4);
    @(posedge clk);
    chk("irq masked", irq, 32'h0000_0000);
    bus(1'b1, A_IM, 32'h0000_0004, 4'h1);
    @(posedge clk);
    chk("irq raised", irq, 32'h0000_0001);
    rd(A_IM, 32'h0000_0004, "irq mask");
    rd(A_IS, 32'h0000_0004, "irq status fatal");
    @(posedge clk);
    chk("irq cleared", irq, 32'h0000_0000);
    pulse(4'h1);
    @(posedge clk);
    chk("irq other masked", irq, 32'h0000_0000);
    rd(A_IS, 32'h0000_0001, "irq status corr");
  endtask
  ////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctl();
    t_aux();
    t_flags();
    t_race();
    t_irq();
    conclude();
  end
endmodule // pdcs_top_tb
bind pdcs_top pdcs_asserts #(.MPS_SUPPORTED(MPS_SUPPORTED)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .err_corr_pulse(err_corr_pulse), .err_nonfatal_pulse(err_nonfatal_pulse),
  .err_fatal_pulse(err_fatal_pulse), .err_unsup_pulse(err_unsup_pulse),
  .aux_pwr_present(aux_pwr_present), .max_payload(max_payload), .aux_pm_en(aux_pm_en),
  .err_report_en(err_report_en), .irq(irq)
);
